// *** dv/irq_core_model.sv ***
`timescale 1ns/1ns
module irq_core_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // pacing
    input wire logic [3:0] ack_delay,
    // request and acknowledge
    input wire logic core_irq_req,
    output logic core_irq_ack
);
    logic [3:0] wait_r;
    // single-cycle ack so a held request is taken once
    always @(posedge core_clk) begin
        if (!rst_n || !core_irq_req || core_irq_ack) begin
            wait_r <= 4'h0;
            core_irq_ack <= 1'b0;
        end else if (wait_r >= ack_delay) begin
            core_irq_ack <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule // irq_core_model

// *** dv/irq_ctl_props.sv ***
`timescale 1ns/1ns
module irq_ctl_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // register bus
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire irq_ctl_pkg::axi_resp_t s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // core side
    input wire logic core_irq_req,
    input wire logic core_irq_ack,
    input wire logic vector_load,
    input wire logic [12:0] vector_addr,
    input wire logic irq
);
    import irq_ctl_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_accept_vector: assert property (ce && core_irq_req && core_irq_ack |=>
        vector_load && !core_irq_req && vector_addr == 13'h0004) else $error("no vector");
    a_load_single: assert property (ce && vector_load |=> !vector_load)
        else $error("long vector load");
    a_load_cause: assert property ($rose(vector_load) |-> $past(core_irq_ack))
        else $error("load without accept");
    a_vector_values: assert property (vector_addr == 13'h0000 || vector_addr == 13'h0004)
        else $error("bad vector");
    a_reset_quiet: assert property ($rose(rst_n) |-> !core_irq_req && !irq && !vector_load)
        else $error("outputs live at reset");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("late read data");
    c_accept: cover property (core_irq_req && core_irq_ack);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_irq: cover property ($rose(irq));
endmodule // irq_ctl_props

bind core_interrupt_control irq_ctl_props irq_ctl_props_inst (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .core_irq_req(core_irq_req), .core_irq_ack(core_irq_ack),
    .vector_load(vector_load), .vector_addr(vector_addr), .irq(irq)
);

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
`include "irq_ctl_defs.svh"
module tb_top;
    import irq_ctl_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic timer_overflow = 1'b0, ext_irq_pin = 1'b0, periph_req = 1'b0;
    logic [3:0] upper_port_pins = 4'h0, ack_delay = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic core_irq_req, core_irq_ack, vector_load, irq;
    axi_resp_t s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd;
    logic [12:0] vector_addr;
    logic [11:0] banks [4] = '{`IC_ADDR_BANK0, `IC_ADDR_BANK1, `IC_ADDR_BANK2, `IC_ADDR_BANK3};
    int num_errors = 0, n_compared = 0;

    initial forever #4 core_clk = ~core_clk;

    core_interrupt_control core_interrupt_control_inst (
        .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .timer_overflow(timer_overflow), .ext_irq_pin(ext_irq_pin),
        .upper_port_pins(upper_port_pins), .periph_req(periph_req),
        .core_irq_req(core_irq_req), .core_irq_ack(core_irq_ack),
        .vector_load(vector_load), .vector_addr(vector_addr), .irq(irq)
    );
    irq_core_model irq_core_model_inst (
        .core_clk(core_clk), .rst_n(rst_n), .ack_delay(ack_delay),
        .core_irq_req(core_irq_req), .core_irq_ack(core_irq_ack)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input axi_resp_t er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1 && !aw_ok) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1 && !w_ok) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic axi_read(input logic [11:0] a, input axi_resp_t er);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge core_clk);
        while (s_axi_arready !== 1'b1) @(posedge core_clk);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input axi_resp_t er);
        axi_read(a, er);
        chk(rd, ed);
    endtask

    // bounded wait: 0 for the core request, 1 for the vector load pulse
    task automatic wait_sig(input int which);
        int n;
        n = 0;
        while (n < 60 && (which == 0 ? core_irq_req : vector_load) !== 1'b1) begin
            @(posedge core_clk);
            n++;
        end
        chk({31'h0, n < 60}, 32'h1);
    endtask

    // pin held high well past the input filter so the edge is not lost
    task automatic fire(input int s);
        @(posedge core_clk);
        case (s)
            0: timer_overflow <= 1'b1;
            1: ext_irq_pin <= 1'b1;
            default: upper_port_pins <= ~upper_port_pins;
        endcase
        @(posedge core_clk);
        timer_overflow <= 1'b0;
        repeat (10) @(posedge core_clk);
        ext_irq_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic t_reset;
        chk({19'h0, vector_addr}, 32'h0);
        chk({30'h0, core_irq_req, irq}, 32'h0);
        axi_read(`IC_ADDR_BANK0, RESP_OKAY);
        chk(rd & 32'hFE, 32'h0);
    endtask

    task automatic t_banks;
        axi_write(`IC_ADDR_BANK1, 8'h38, RESP_OKAY);
        for (int b = 0; b < 4; b++) rd_chk(banks[b], 32'h38, RESP_OKAY);
        axi_write(`IC_ADDR_BANK2, 8'h00, RESP_OKAY);
        rd_chk(`IC_ADDR_BANK3, 32'h0, RESP_OKAY);
        rd_chk(12'h100, 32'h0, RESP_SLVERR);
        axi_write(12'h100, 8'hFF, RESP_SLVERR);
    endtask

    // source s: 0 timer, 1 external pin, 2 port change
    task automatic t_sources;
        logic [7:0] en;
        logic [7:0] fl;
        for (int s = 0; s < 3; s++) begin
            en = 8'h20 >> s;
            fl = 8'h04 >> s;
            ack_delay <= 4'(s * 5);
            axi_write(`IC_ADDR_BANK0, 8'h00, RESP_OKAY);
            axi_write(`IC_ADDR_BANK0, en, RESP_OKAY);
            fire(s);
            chk({31'h0, core_irq_req}, 32'h0);
            rd_chk(`IC_ADDR_BANK2, {24'h0, en | fl}, RESP_OKAY);
            axi_write(`IC_ADDR_BANK3, 8'h80 | en | fl, RESP_OKAY);
            wait_sig(0);
            wait_sig(1);
            chk({19'h0, vector_addr}, {19'h0, `IRQ_VECTOR});
            rd_chk(`IC_ADDR_BANK1, {24'h0, en | fl}, RESP_OKAY);
            axi_write(`IC_ADDR_BANK0, 8'h00, RESP_OKAY);
            rd_chk(`IC_ADDR_BANK0, {24'h0, s == 2 ? fl : 8'h00}, RESP_OKAY);
            rd_chk(`IC_ADDR_PORT_SNAP, {28'h0, upper_port_pins}, RESP_OKAY);
            repeat (4) @(posedge core_clk);
            axi_write(`IC_ADDR_BANK0, 8'h00, RESP_OKAY);
            rd_chk(`IC_ADDR_BANK0, 32'h0, RESP_OKAY);
        end
    endtask

    task automatic t_periph;
        axi_write(`IC_ADDR_BANK0, 8'h80, RESP_OKAY);
        periph_req <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk({31'h0, core_irq_req}, 32'h0);
        axi_write(`IC_ADDR_BANK0, 8'hC0, RESP_OKAY);
        wait_sig(0);
        wait_sig(1);
        rd_chk(`IC_ADDR_BANK0, 32'h40, RESP_OKAY);
        periph_req <= 1'b0;
    endtask

    task automatic t_events;
        rd_chk(`IC_ADDR_EVT_STATUS, 32'hF, RESP_OKAY);
        axi_write(`IC_ADDR_EVT_STATUS, 8'h0F, RESP_OKAY);
        rd_chk(`IC_ADDR_EVT_STATUS, 32'h0, RESP_OKAY);
        fire(0);
        rd_chk(`IC_ADDR_EVT_STATUS, 32'h1, RESP_OKAY);
        rd_chk(`IC_ADDR_BANK0, 32'h44, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        axi_write(`IC_ADDR_EVT_MASK, 8'h01, RESP_OKAY);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        axi_write(`IC_ADDR_EVT_STATUS, 8'h01, RESP_OKAY);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic final_report;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge core_clk);
        num_errors++;
        final_report();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_banks();
        t_sources();
        t_periph();
        t_events();
        final_report();
    end
endmodule // tb_top

// *** verilog/core_interrupt_control.sv ***
`timescale 1ns/1ns
`include "irq_ctl_defs.svh"
// Behaviour
// - one 8-bit read/write interrupt control register
// - bits: two gates, three enables, three flags
// - reset clears bits 7..1, bit 0 undefined
// - peripheral enable gates peripheral requests
// - timer enable masks timer overflow flag
// - external pin enable masks pin flag
// - port change enable masks change flag
// - timer overflow sets flag; software clears
// - external pin event sets sticky flag
// - flags set regardless of any enable
// - taken interrupt loads fixed vector address
// - four bank addresses reach one register
module core_interrupt_control (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output irq_ctl_pkg::axi_resp_t s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output irq_ctl_pkg::axi_resp_t s_axi_rresp,
    // interrupt sources
    input wire logic timer_overflow,
    input wire logic ext_irq_pin,
    input wire logic [3:0] upper_port_pins,
    input wire logic periph_req,
    // processor core side
    output logic core_irq_req,
    input wire logic core_irq_ack,
    output logic vector_load,
    output logic [12:0] vector_addr,
    // event interrupt
    output logic irq
);
    import irq_ctl_pkg::*;

    logic [4:0] pins_q;
    logic port_mismatch;
    logic ext_q_d_r;
    logic ext_rise;
    logic snap_rd;

    pin_sync #(.W(5)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .pin_in({upper_port_pins, ext_irq_pin}),
        .pin_q(pins_q)
    );

    port_change_detect u_pcd (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .pins(pins_q[4:1]),
        .snap(snap_rd),
        .mismatch(port_mismatch)
    );

    // external event is a rising edge of the filtered pin
    assign ext_rise = pins_q[0] & ~ext_q_d_r;

    // ---------------- bus slave ----------------
    logic aw_got_r, aw_got_nxt;
    logic w_got_r, w_got_nxt;
    logic [11:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    wr_state_t wst_r, wst_nxt;
    logic bvalid_nxt;
    axi_resp_t bresp_r, bresp_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    axi_resp_t rresp_r, rresp_nxt;
    logic wr_go, wr_ic, wr_stat, wr_mask, wr_hit, rd_go;

    function automatic logic is_ic(input logic [11:0] a);
        return (a == `IC_ADDR_BANK0) || (a == `IC_ADDR_BANK1) ||
               (a == `IC_ADDR_BANK2) || (a == `IC_ADDR_BANK3);
    endfunction

    // register state
    logic [7:0] ic_r, ic_nxt;
    logic [3:0] ev_stat_r, ev_stat_nxt, ev_mask_r, ev_mask_nxt, ev_set;
    logic req_r, req_nxt, vld_r, vld_nxt, irq_r, irq_nxt, taken;
    logic [12:0] vaddr_r, vaddr_nxt;

    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        wst_nxt = wst_r;
        bresp_nxt = bresp_r;
        bvalid_nxt = 1'b0;
        if (s_axi_awvalid && awready_r) begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        wr_go = (wst_r == WR_IDLE) && aw_got_r && w_got_r;
        wr_ic = wr_go && is_ic(awaddr_r) && wstrb_r[0];
        wr_stat = wr_go && (awaddr_r == `IC_ADDR_EVT_STATUS) && wstrb_r[0];
        wr_mask = wr_go && (awaddr_r == `IC_ADDR_EVT_MASK) && wstrb_r[0];
        wr_hit = is_ic(awaddr_r) || (awaddr_r == `IC_ADDR_EVT_STATUS) ||
                 (awaddr_r == `IC_ADDR_EVT_MASK) || (awaddr_r == `IC_ADDR_PORT_SNAP);
        case (wst_r)
            WR_IDLE: begin
                if (wr_go) begin
                    wst_nxt = WR_RESP;
                    bresp_nxt = wr_hit ? axi_resp_t'(RESP_OKAY) : axi_resp_t'(RESP_SLVERR);
                    aw_got_nxt = 1'b0;
                    w_got_nxt = 1'b0;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    wst_nxt = WR_IDLE;
                end
            end
            default: wst_nxt = WR_IDLE;
        endcase
        bvalid_nxt = (wst_nxt == WR_RESP);
        // one write in flight: hold off new beats until the response is gone
        awready_nxt = !aw_got_nxt && (wst_nxt == WR_IDLE);
        wready_nxt = !w_got_nxt && (wst_nxt == WR_IDLE);

        rd_go = s_axi_arvalid && arready_r;
        snap_rd = rd_go && (s_axi_araddr == `IC_ADDR_PORT_SNAP);
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = axi_resp_t'(RESP_OKAY);
            if (is_ic(s_axi_araddr)) begin
                rdata_nxt = {24'h000000, ic_r};
            end else if (s_axi_araddr == `IC_ADDR_PORT_SNAP) begin
                rdata_nxt = {28'h0000000, pins_q[4:1]};
            end else if (s_axi_araddr == `IC_ADDR_EVT_STATUS) begin
                rdata_nxt = {28'h0000000, ev_stat_r};
            end else if (s_axi_araddr == `IC_ADDR_EVT_MASK) begin
                rdata_nxt = {28'h0000000, ev_mask_r};
            end else begin
                rdata_nxt = 32'h00000000;
                rresp_nxt = axi_resp_t'(RESP_SLVERR);
            end
        end
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            wst_r <= WR_IDLE;
            s_axi_bvalid <= 1'b0;
            bresp_r <= axi_resp_t'(RESP_OKAY);
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= axi_resp_t'(RESP_OKAY);
        end else if (ce) begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            wst_r <= wst_nxt;
            s_axi_bvalid <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ---------------- control register and core request ----------------
    always_comb begin
        ic_nxt = ic_r;
        if (wr_ic) begin
            ic_nxt = wdata_r[7:0];
        end
        // hardware sets win over a software clear in the same cycle
        if (timer_overflow) begin
            ic_nxt[`IC_BIT_TOF] = 1'b1;
        end
        if (ext_rise) begin
            ic_nxt[`IC_BIT_EXF] = 1'b1;
        end
        if (port_mismatch) begin
            ic_nxt[`IC_BIT_PCF] = 1'b1;
        end
        taken = core_irq_ack && req_r;
        if (taken) begin
            ic_nxt[`IC_BIT_GLOBAL_EN] = 1'b0;
        end
        req_nxt = ic_nxt[`IC_BIT_GLOBAL_EN] & (
            (ic_nxt[`IC_BIT_TIMER_EN] & ic_nxt[`IC_BIT_TOF]) |
            (ic_nxt[`IC_BIT_EXIE] & ic_nxt[`IC_BIT_EXF]) |
            (ic_nxt[`IC_BIT_PCIE] & ic_nxt[`IC_BIT_PCF] === 1'b1) |
            (ic_nxt[`IC_BIT_PERIPH_EN] & periph_req));
        vld_nxt = taken;
        vaddr_nxt = taken ? `IRQ_VECTOR : vaddr_r;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // flag bit 0 keeps no reset value
            ic_r[7:1] <= `IC_RESET_UPPER;
            req_r <= 1'b0;
            vld_r <= 1'b0;
            vaddr_r <= 13'h0000;
            ext_q_d_r <= 1'b0;
        end else if (ce) begin
            ic_r <= ic_nxt;
            req_r <= req_nxt;
            vld_r <= vld_nxt;
            vaddr_r <= vaddr_nxt;
            ext_q_d_r <= pins_q[0];
        end
    end

    assign core_irq_req = req_r;
    assign vector_load = vld_r;
    assign vector_addr = vaddr_r;

    // ---------------- event status, mask, interrupt line ----------------
    always_comb begin
        ev_set = 4'h0;
        ev_set[`EV_BIT_TIMER] = timer_overflow;
        ev_set[`EV_BIT_EXT] = ext_rise;
        ev_set[`EV_BIT_PORT] = port_mismatch;
        ev_set[`EV_BIT_TAKEN] = taken;
        ev_stat_nxt = ev_stat_r;
        if (wr_stat) begin
            ev_stat_nxt = ev_stat_r & ~wdata_r[3:0];
        end
        ev_stat_nxt = ev_stat_nxt | ev_set;
        ev_mask_nxt = wr_mask ? wdata_r[3:0] : ev_mask_r;
        irq_nxt = |(ev_stat_nxt & ev_mask_nxt);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ev_stat_r <= `EV_RESET;
            ev_mask_r <= `EV_RESET;
            irq_r <= 1'b0;
        end else if (ce) begin
            ev_stat_r <= ev_stat_nxt;
            ev_mask_r <= ev_mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign irq = irq_r;
endmodule // core_interrupt_control

// *** verilog/irq_ctl_defs.svh ***
`ifndef IRQ_CTL_DEFS_SVH
`define IRQ_CTL_DEFS_SVH

// printed offsets are register indexes; byte address is four times the index
`define IC_IDX_BANK0 12'h00B
`define IC_IDX_BANK1 12'h08B
`define IC_IDX_BANK2 12'h10B
`define IC_IDX_BANK3 12'h18B
`define IC_ADDR_BANK0 12'h02C
`define IC_ADDR_BANK1 12'h22C
`define IC_ADDR_BANK2 12'h42C
`define IC_ADDR_BANK3 12'h62C
`define IC_ADDR_PORT_SNAP 12'h800
`define IC_ADDR_EVT_STATUS 12'h804
`define IC_ADDR_EVT_MASK 12'h808

// interrupt_control field positions
`define IC_BIT_GLOBAL_EN 7
`define IC_BIT_PERIPH_EN 6
`define IC_BIT_TIMER_EN 5
`define IC_BIT_EXIE 4
`define IC_BIT_PCIE 3
`define IC_BIT_TOF 2
`define IC_BIT_EXF 1
`define IC_BIT_PCF 0

// event status / mask field positions
`define EV_BIT_TIMER 0
`define EV_BIT_EXT 1
`define EV_BIT_PORT 2
`define EV_BIT_TAKEN 3
`define EV_WIDTH 4

`define IC_RESET_UPPER 7'h00
`define EV_RESET 4'h0
`define IRQ_VECTOR 13'h0004
`define PC_WIDTH 13
`define SYNC_STAGES 3

`endif

// *** verilog/irq_ctl_pkg.sv ***
package irq_ctl_pkg;
    typedef logic [1:0] axi_resp_t;
    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } resp_code_t;
    typedef enum logic [0:0] {
        WR_IDLE = 1'b0,
        WR_RESP = 1'b1
    } wr_state_t;
endpackage

// *** verilog/pin_sync.sv ***
`timescale 1ns/1ns
`include "irq_ctl_defs.svh"
module pin_sync #(
    parameter int W = 1
) (
    // clock and control
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // pins in, filtered level out
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_q
);
    logic [W-1:0] st1_r, st2_r, st3_r, q_r;
    logic [W-1:0] q_nxt;

    // a bit follows only once the second and third stage agree
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_comb begin
                q_nxt[g] = (st2_r[g] == st3_r[g]) ? st3_r[g] : q_r[g];
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st1_r <= '0;
            st2_r <= '0;
            st3_r <= '0;
            q_r <= '0;
        end else if (ce) begin
            st1_r <= pin_in;
            st2_r <= st1_r;
            st3_r <= st2_r;
            q_r <= q_nxt;
        end
    end

    assign pin_q = q_r;
endmodule // pin_sync

// *** verilog/port_change_detect.sv ***
`timescale 1ns/1ns
module port_change_detect (
    // clock and control
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // filtered upper port pins and software read strobe
    input wire logic [3:0] pins,
    input wire logic snap,
    // mismatch against the last read value
    output logic mismatch
);
    logic [3:0] latched_r, latched_nxt;
    logic mismatch_r, mismatch_nxt;

    always_comb begin
        latched_nxt = snap ? pins : latched_r;
        // a read ends the mismatch from the next cycle on
        mismatch_nxt = (pins != latched_nxt);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            latched_r <= 4'h0;
            mismatch_r <= 1'b0;
        end else if (ce) begin
            latched_r <= latched_nxt;
            mismatch_r <= mismatch_nxt;
        end
    end

    assign mismatch = mismatch_r;
endmodule // port_change_detect
